// ==== design/timer8_pkg.sv ====
`default_nettype none
package timer8_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] CTRL_A_OFF = 8'h00;
  localparam logic [7:0] CTRL_B_OFF = 8'h04;
  localparam logic [7:0] COUNT_OFF = 8'h08;
  localparam logic [7:0] CMP_A_OFF = 8'h0c;
  localparam logic [7:0] CMP_B_OFF = 8'h10;
  localparam logic [7:0] FLAGS_OFF = 8'h14;
  localparam logic [7:0] IRQ_EN_OFF = 8'h18;
  localparam logic [7:0] ASYNC_OFF = 8'h1c;
  localparam logic [7:0] PORT_OFF = 8'h20;

  // control_register_a fields
  localparam int WGM_LO_POS = 0;
  localparam int COM_B_POS = 4;
  localparam int COM_A_POS = 6;
  // control_register_b fields
  localparam int CS_POS = 0;
  localparam int WGM_HI_POS = 3;
  localparam int FOC_B_POS = 6;
  localparam int FOC_A_POS = 7;
  // flag / enable positions
  localparam int OVF_POS = 0;
  localparam int FLAG_A_POS = 1;
  localparam int FLAG_B_POS = 2;
  // port control positions
  localparam int PORT_DATA_POS = 0;
  localparam int PORT_DIR_POS = 2;

  // counter limits
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hff;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;

  // waveform mode codes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_TOP = 3'h5;
  localparam logic [2:0] WGM_FAST_TOP = 3'h7;

  // compare output mode codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam int PRESC_W = 10;

  // prescaler tap mask per clock select code (divisor minus one)
  function automatic logic [PRESC_W-1:0] tap_mask(input logic [2:0] cs);
    logic [PRESC_W-1:0] m;
    m = 10'h000;
    case (cs)
      3'h2: m = 10'h007;
      3'h3: m = 10'h01f;
      3'h4: m = 10'h03f;
      3'h5: m = 10'h07f;
      3'h6: m = 10'h0ff;
      3'h7: m = 10'h3ff;
      default: m = 10'h000;
    endcase
    return m;
  endfunction

endpackage
`default_nettype wire

// ==== design/tick_gen.sv ====
`default_nettype none
module tick_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // source control
  input wire logic async_sel,
  input wire logic [2:0] clock_select,
  // oscillator pins
  input wire logic osc_in,
  output logic osc_out,
  // timer tick
  output logic tick
);

  logic osc_prev_r;
  logic src_en;
  logic [timer8_pkg::PRESC_W-1:0] presc_r;
  logic [timer8_pkg::PRESC_W-1:0] mask;

  // remember the oscillator level for rising edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_in;
    end
  end

  // source is the io clock, or oscillator edges when async is selected
  assign src_en = async_sel ? (osc_in & ~osc_prev_r) : 1'b1;

  // free running prescaler advanced by the chosen source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_r <= '0;
    end else if (src_en) begin
      presc_r <= presc_r + 10'h001;
    end
  end

  // tap selection; clock select zero stops the timer
  assign mask = timer8_pkg::tap_mask(clock_select);
  assign tick = (clock_select != timer8_pkg::CS_STOP) && src_en
                && ((presc_r & mask) == mask);

  // amplifier output is the inverted oscillator input while in use
  assign osc_out = async_sel & ~osc_in;

endmodule
`default_nettype wire

// ==== design/timer8_core.sv ====
// Implementation choices: the APB register port and the address map.
`default_nettype none
module timer8_core (
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // oscillator pins
  input wire logic OSC_PIN_IN,
  output logic OSC_PIN_OUT,
  // interrupt requests and service acknowledges
  output logic OVERFLOW_IRQ,
  output logic COMPARE_A_IRQ,
  output logic COMPARE_B_IRQ,
  input wire logic OVERFLOW_ACK,
  input wire logic COMPARE_A_ACK,
  input wire logic COMPARE_B_ACK,
  // compare pins
  output logic COMPARE_OUTPUT_A,
  output logic COMPARE_OUTPUT_A_OE,
  output logic COMPARE_OUTPUT_B,
  output logic COMPARE_OUTPUT_B_OE
);

  // address match helper used by every register decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // control state
  logic [1:0] wgm_lo_r;
  logic wgm_hi_r;
  logic [2:0] clock_select_r;
  logic [1:0] com_r [2];
  logic async_clock_select_r;
  logic [2:0] irq_en_r;
  logic [1:0] port_data_r;
  logic [1:0] port_dir_r;

  // counter state
  logic [7:0] count_value_r;
  logic [7:0] count_value_nxt;
  logic count_down_r;
  logic count_down_nxt;
  logic block_r;

  // compare state
  logic [7:0] cmp_act_r [2];
  logic [7:0] cmp_buf_r [2];
  logic [1:0] out_state_r;
  logic overflow_flag_r;
  logic [1:0] compare_flag_r;

  // decoded signals
  logic wr;
  logic rd_ok;
  logic timer_tick;
  logic [2:0] mode;
  logic is_pwm;
  logic is_fast;
  logic is_phase;
  logic top_is_a;
  logic [7:0] top_val;
  logic at_bottom;
  logic at_max;
  logic at_top;
  logic count_wr;
  logic ovf_set;
  logic buf_load;
  logic [1:0] match;
  logic [1:0] match_hit;
  logic [1:0] force_str;
  logic [1:0] cmp_wr;
  logic [2:0] flag_w1c;

  // tick source and prescaler
  tick_gen u_tick (
    .clk(MCLK),
    .rst(SYS_RST),
    .async_sel(async_clock_select_r),
    .clock_select(clock_select_r),
    .osc_in(OSC_PIN_IN),
    .osc_out(OSC_PIN_OUT),
    .tick(timer_tick)
  );

  // apb handshake, zero wait states
  assign wr = PSEL & PENABLE & PWRITE;
  assign PREADY = 1'b1;
  assign rd_ok = hit(PADDR, timer8_pkg::CTRL_A_OFF) | hit(PADDR, timer8_pkg::CTRL_B_OFF)
               | hit(PADDR, timer8_pkg::COUNT_OFF) | hit(PADDR, timer8_pkg::CMP_A_OFF)
               | hit(PADDR, timer8_pkg::CMP_B_OFF) | hit(PADDR, timer8_pkg::FLAGS_OFF)
               | hit(PADDR, timer8_pkg::IRQ_EN_OFF) | hit(PADDR, timer8_pkg::ASYNC_OFF)
               | hit(PADDR, timer8_pkg::PORT_OFF);
  assign PSLVERR = PSEL & PENABLE & ~rd_ok;

  // mode decode from the split waveform field
  assign mode = {wgm_hi_r, wgm_lo_r};
  assign is_fast = (mode == timer8_pkg::WGM_FAST_MAX) || (mode == timer8_pkg::WGM_FAST_TOP);
  assign is_phase = (mode == timer8_pkg::WGM_PC_MAX) || (mode == timer8_pkg::WGM_PC_TOP);
  assign is_pwm = is_fast | is_phase;
  assign top_is_a = (mode == timer8_pkg::WGM_CTC) || (mode == timer8_pkg::WGM_PC_TOP)
                  || (mode == timer8_pkg::WGM_FAST_TOP);
  assign top_val = top_is_a ? cmp_act_r[0] : timer8_pkg::MAX_VAL;

  // extreme value indications
  assign at_bottom = count_value_r == timer8_pkg::BOTTOM_VAL;
  assign at_max = count_value_r == timer8_pkg::MAX_VAL;
  assign at_top = count_value_r == top_val;

  // write strobes
  assign count_wr = wr & hit(PADDR, timer8_pkg::COUNT_OFF);
  assign cmp_wr[0] = wr & hit(PADDR, timer8_pkg::CMP_A_OFF);
  assign cmp_wr[1] = wr & hit(PADDR, timer8_pkg::CMP_B_OFF);
  assign force_str[0] = wr & hit(PADDR, timer8_pkg::CTRL_B_OFF)
                        & PWDATA[timer8_pkg::FOC_A_POS] & ~is_pwm;
  assign force_str[1] = wr & hit(PADDR, timer8_pkg::CTRL_B_OFF)
                        & PWDATA[timer8_pkg::FOC_B_POS] & ~is_pwm;
  assign flag_w1c = (wr & hit(PADDR, timer8_pkg::FLAGS_OFF))
                    ? PWDATA[2:0] : 3'h0;

  // buffered compare values load at top of the count in pwm modes
  assign buf_load = timer_tick & is_pwm & at_top;

  // next count and direction for one tick
  always_comb begin
    count_value_nxt = count_value_r;
    count_down_nxt = is_phase ? count_down_r : 1'b0;
    ovf_set = 1'b0;
    if (timer_tick) begin
      if (is_phase) begin
        if (!count_down_r) begin
          if (at_top) begin
            count_down_nxt = 1'b1;
            count_value_nxt = count_value_r - 8'h01;
          end else begin
            count_value_nxt = count_value_r + 8'h01;
          end
        end else if (at_bottom) begin
          count_down_nxt = 1'b0;
          count_value_nxt = count_value_r + 8'h01;
        end else begin
          count_value_nxt = count_value_r - 8'h01;
          ovf_set = count_value_r == 8'h01;
        end
      end else if (is_fast) begin
        count_value_nxt = at_top ? timer8_pkg::BOTTOM_VAL : count_value_r + 8'h01;
        ovf_set = at_top;
      end else if (mode == timer8_pkg::WGM_CTC && at_top) begin
        count_value_nxt = timer8_pkg::BOTTOM_VAL;
        ovf_set = at_max;
      end else begin
        count_value_nxt = count_value_r + 8'h01;
        ovf_set = at_max;
      end
    end
    if (count_wr) begin
      count_value_nxt = PWDATA[7:0];
    end
  end

  // counter register
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count_value_r <= timer8_pkg::COUNT_RST;
      count_down_r <= 1'b0;
    end else begin
      count_value_r <= count_value_nxt;
      count_down_r <= count_down_nxt;
    end
  end

  // match blocking after a count write, released by the next tick
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      block_r <= 1'b0;
    end else if (count_wr) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wgm_lo_r <= 2'h0;
      wgm_hi_r <= 1'b0;
      clock_select_r <= timer8_pkg::CS_STOP;
      com_r[0] <= timer8_pkg::COM_OFF;
      com_r[1] <= timer8_pkg::COM_OFF;
      async_clock_select_r <= 1'b0;
      irq_en_r <= 3'h0;
      port_data_r <= 2'h0;
      port_dir_r <= 2'h0;
    end else if (wr) begin
      if (hit(PADDR, timer8_pkg::CTRL_A_OFF)) begin
        wgm_lo_r <= PWDATA[timer8_pkg::WGM_LO_POS +: 2];
        com_r[0] <= PWDATA[timer8_pkg::COM_A_POS +: 2];
        com_r[1] <= PWDATA[timer8_pkg::COM_B_POS +: 2];
      end
      if (hit(PADDR, timer8_pkg::CTRL_B_OFF)) begin
        clock_select_r <= PWDATA[timer8_pkg::CS_POS +: 3];
        wgm_hi_r <= PWDATA[timer8_pkg::WGM_HI_POS];
      end
      if (hit(PADDR, timer8_pkg::ASYNC_OFF)) begin
        async_clock_select_r <= PWDATA[0];
      end
      if (hit(PADDR, timer8_pkg::IRQ_EN_OFF)) begin
        irq_en_r <= PWDATA[2:0];
      end
      if (hit(PADDR, timer8_pkg::PORT_OFF)) begin
        port_data_r <= PWDATA[timer8_pkg::PORT_DATA_POS +: 2];
        port_dir_r <= PWDATA[timer8_pkg::PORT_DIR_POS +: 2];
      end
    end
  end

  // overflow flag: hardware set wins over software or service clear
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      overflow_flag_r <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag_r <= 1'b1;
    end else if (flag_w1c[timer8_pkg::OVF_POS] | OVERFLOW_ACK) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // per channel compare, buffer, flag and output state
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic clr;
    logic ack;
    logic act;
    logic pwm_set;
    logic pwm_clr;

    assign match[ch] = count_value_r == cmp_act_r[ch];
    assign match_hit[ch] = timer_tick & match[ch] & ~block_r;
    assign ack = (ch == 0) ? COMPARE_A_ACK : COMPARE_B_ACK;
    assign clr = flag_w1c[timer8_pkg::FLAG_A_POS + ch] | ack;

    // compare value: direct when unbuffered, via buffer in pwm modes
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        cmp_act_r[ch] <= timer8_pkg::CMP_RST;
        cmp_buf_r[ch] <= timer8_pkg::CMP_RST;
      end else begin
        if (cmp_wr[ch]) begin
          cmp_buf_r[ch] <= PWDATA[7:0];
        end
        if (cmp_wr[ch] && !is_pwm) begin
          cmp_act_r[ch] <= PWDATA[7:0];
        end else if (buf_load) begin
          cmp_act_r[ch] <= cmp_buf_r[ch];
        end
      end
    end

    // compare flag set on the tick after a match
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        compare_flag_r[ch] <= 1'b0;
      end else if (match_hit[ch]) begin
        compare_flag_r[ch] <= 1'b1;
      end else if (clr) begin
        compare_flag_r[ch] <= 1'b0;
      end
    end

    // pwm set and clear events for non-inverting and inverting modes
    always_comb begin
      pwm_set = 1'b0;
      pwm_clr = 1'b0;
      act = match_hit[ch] | force_str[ch];
      if (is_fast) begin
        if (com_r[ch] == timer8_pkg::COM_CLEAR) begin
          pwm_clr = match_hit[ch];
          pwm_set = timer_tick & at_top & ~match_hit[ch];
        end else if (com_r[ch] == timer8_pkg::COM_SET) begin
          pwm_set = match_hit[ch];
          pwm_clr = timer_tick & at_top & ~match_hit[ch];
        end
      end else if (is_phase) begin
        if (com_r[ch] == timer8_pkg::COM_CLEAR) begin
          pwm_clr = match_hit[ch] & ~count_down_r;
          pwm_set = match_hit[ch] & count_down_r;
        end else if (com_r[ch] == timer8_pkg::COM_SET) begin
          pwm_set = match_hit[ch] & ~count_down_r;
          pwm_clr = match_hit[ch] & count_down_r;
        end
      end
    end

    // output state register, unaffected by mode changes themselves
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        out_state_r[ch] <= 1'b0;
      end else if (!is_pwm && act) begin
        unique case (com_r[ch])
          timer8_pkg::COM_OFF: out_state_r[ch] <= out_state_r[ch];
          timer8_pkg::COM_TOGGLE: out_state_r[ch] <= ~out_state_r[ch];
          timer8_pkg::COM_CLEAR: out_state_r[ch] <= 1'b0;
          timer8_pkg::COM_SET: out_state_r[ch] <= 1'b1;
        endcase
      end else if (is_pwm && pwm_set) begin
        out_state_r[ch] <= 1'b1;
      end else if (is_pwm && pwm_clr) begin
        out_state_r[ch] <= 1'b0;
      end else if (is_pwm && ch == 0 && wgm_hi_r && match_hit[ch]
                   && com_r[ch] == timer8_pkg::COM_TOGGLE) begin
        out_state_r[ch] <= ~out_state_r[ch];
      end else begin
        out_state_r[ch] <= out_state_r[ch];
      end
    end
  end

  // interrupt requests from enabled flags
  assign OVERFLOW_IRQ = overflow_flag_r & irq_en_r[timer8_pkg::OVF_POS];
  assign COMPARE_A_IRQ = compare_flag_r[0] & irq_en_r[timer8_pkg::FLAG_A_POS];
  assign COMPARE_B_IRQ = compare_flag_r[1] & irq_en_r[timer8_pkg::FLAG_B_POS];

  // port override by the output state; direction stays with the port
  assign COMPARE_OUTPUT_A = (com_r[0] != timer8_pkg::COM_OFF) ? out_state_r[0]
                                                               : port_data_r[0];
  assign COMPARE_OUTPUT_B = (com_r[1] != timer8_pkg::COM_OFF) ? out_state_r[1]
                                                               : port_data_r[1];
  assign COMPARE_OUTPUT_A_OE = port_dir_r[0];
  assign COMPARE_OUTPUT_B_OE = port_dir_r[1];

  // read data mux; compare reads follow the buffer when buffered
  always_comb begin
    PRDATA = 32'h0000_0000;
    if (PSEL && !PWRITE) begin
      if (hit(PADDR, timer8_pkg::CTRL_A_OFF)) begin
        PRDATA[timer8_pkg::WGM_LO_POS +: 2] = wgm_lo_r;
        PRDATA[timer8_pkg::COM_B_POS +: 2] = com_r[1];
        PRDATA[timer8_pkg::COM_A_POS +: 2] = com_r[0];
      end
      if (hit(PADDR, timer8_pkg::CTRL_B_OFF)) begin
        PRDATA[timer8_pkg::CS_POS +: 3] = clock_select_r;
        PRDATA[timer8_pkg::WGM_HI_POS] = wgm_hi_r;
      end
      if (hit(PADDR, timer8_pkg::COUNT_OFF)) begin
        PRDATA[7:0] = count_value_r;
      end
      if (hit(PADDR, timer8_pkg::CMP_A_OFF)) begin
        PRDATA[7:0] = is_pwm ? cmp_buf_r[0] : cmp_act_r[0];
      end
      if (hit(PADDR, timer8_pkg::CMP_B_OFF)) begin
        PRDATA[7:0] = is_pwm ? cmp_buf_r[1] : cmp_act_r[1];
      end
      if (hit(PADDR, timer8_pkg::FLAGS_OFF)) begin
        PRDATA[2:0] = {compare_flag_r, overflow_flag_r};
      end
      if (hit(PADDR, timer8_pkg::IRQ_EN_OFF)) begin
        PRDATA[2:0] = irq_en_r;
      end
      if (hit(PADDR, timer8_pkg::ASYNC_OFF)) begin
        PRDATA[0] = async_clock_select_r;
      end
      if (hit(PADDR, timer8_pkg::PORT_OFF)) begin
        PRDATA[timer8_pkg::PORT_DATA_POS +: 2] = port_data_r;
        PRDATA[timer8_pkg::PORT_DIR_POS +: 2] = port_dir_r;
      end
    end
  end

endmodule
`default_nettype wire

// ==== dv/timer8_checker.sv ====
`default_nettype none
module timer8_checker (
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // pins and interrupts
  input wire logic OSC_PIN_IN,
  input wire logic OSC_PIN_OUT,
  input wire logic OVERFLOW_IRQ,
  input wire logic COMPARE_A_IRQ,
  input wire logic COMPARE_B_IRQ,
  input wire logic COMPARE_B_ACK,
  input wire logic COMPARE_OUTPUT_A,
  input wire logic COMPARE_OUTPUT_B_OE
);
  logic wr;
  logic [2:0] cs_r;
  logic [2:0] en_r;
  logic [1:0] com_a_r;
  logic port_a_r;
  logic async_r;

  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // write strobe at the committing edge
  assign wr = PSEL && PENABLE && PWRITE;

  // shadow of the control fields the properties depend on
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cs_r <= 3'h0;
      en_r <= 3'h0;
      com_a_r <= 2'h0;
      port_a_r <= 1'b0;
      async_r <= 1'b0;
    end else if (wr) begin
      if (PADDR == timer8_pkg::CTRL_B_OFF) cs_r <= PWDATA[2:0];
      if (PADDR == timer8_pkg::IRQ_EN_OFF) en_r <= PWDATA[2:0];
      if (PADDR == timer8_pkg::CTRL_A_OFF) com_a_r <= PWDATA[7:6];
      if (PADDR == timer8_pkg::PORT_OFF) port_a_r <= PWDATA[0];
      if (PADDR == timer8_pkg::ASYNC_OFF) async_r <= PWDATA[0];
    end
  end

  a_reset_quiet: assert property ($fell(SYS_RST) |-> !OVERFLOW_IRQ && !COMPARE_OUTPUT_B_OE)
    else $error("outputs active after reset");
  a_osc_drive: assert property (OSC_PIN_OUT == (async_r && !OSC_PIN_IN))
    else $error("oscillator output wrong");
  a_irq_masked: assert property (({COMPARE_B_IRQ, COMPARE_A_IRQ, OVERFLOW_IRQ} & ~en_r) == 3'h0)
    else $error("masked interrupt raised");
  a_ack_clears: assert property (COMPARE_B_ACK && cs_r == 3'h0 |-> ##1 !COMPARE_B_IRQ)
    else $error("acknowledge left flag set");
  a_flag_w1c: assert property (wr && PADDR == timer8_pkg::FLAGS_OFF && PWDATA[0] && cs_r == 3'h0
    |=> !OVERFLOW_IRQ)
    else $error("write one left flag set");
  a_stop_hold: assert property (cs_r == 3'h0 && !COMPARE_A_IRQ
    && !(wr && PADDR == timer8_pkg::IRQ_EN_OFF) |=> !COMPARE_A_IRQ)
    else $error("flag set while stopped");
  a_dir_follow: assert property (wr && PADDR == timer8_pkg::PORT_OFF
    |=> COMPARE_OUTPUT_B_OE == $past(PWDATA[3]))
    else $error("pin direction not from port");
  a_port_pass: assert property (com_a_r == 2'h0 |-> COMPARE_OUTPUT_A == port_a_r)
    else $error("port data not on pin");
  a_unmapped_err: assert property (PSEL && PENABLE && PADDR > timer8_pkg::PORT_OFF
    |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ==== dv/counter8_output_compare_tb_top.sv ====
`default_nettype none
module counter8_output_compare_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic OSC_PIN_IN = 1'b0;
  logic COMPARE_B_ACK = 1'b0;
  logic COMPARE_A_ACK = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, OSC_PIN_OUT, OVERFLOW_IRQ, COMPARE_A_IRQ, COMPARE_B_IRQ;
  logic COMPARE_OUTPUT_A, COMPARE_OUTPUT_A_OE, COMPARE_OUTPUT_B, COMPARE_OUTPUT_B_OE;
  logic [31:0] rdat;
  logic serr;
  int errors = 0;
  int compares = 0;

  // device under test, overflow acknowledge tied low
  timer8_core u_dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OSC_PIN_IN(OSC_PIN_IN), .OSC_PIN_OUT(OSC_PIN_OUT), .OVERFLOW_IRQ(OVERFLOW_IRQ),
    .COMPARE_A_IRQ(COMPARE_A_IRQ), .COMPARE_B_IRQ(COMPARE_B_IRQ), .OVERFLOW_ACK(1'b0),
    .COMPARE_A_ACK(COMPARE_A_ACK), .COMPARE_B_ACK(COMPARE_B_ACK),
    .COMPARE_OUTPUT_A(COMPARE_OUTPUT_A),
    .COMPARE_OUTPUT_A_OE(COMPARE_OUTPUT_A_OE), .COMPARE_OUTPUT_B(COMPARE_OUTPUT_B),
    .COMPARE_OUTPUT_B_OE(COMPARE_OUTPUT_B_OE)
  );

  // 250 mhz clock
  always #2 MCLK = ~MCLK;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) begin
      @(posedge MCLK);
    end
    rdat = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask

  function automatic logic [31:0] pins();
    return {28'h0, COMPARE_OUTPUT_B_OE, COMPARE_OUTPUT_A_OE, COMPARE_OUTPUT_B, COMPARE_OUTPUT_A};
  endfunction

  task automatic t_reset;
    for (int i = 0; i <= 8; i++) begin
      rdc("reset value", 8'(i * 4), 32'h0);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, serr});
  endtask

  task automatic t_count;
    wr(timer8_pkg::COUNT_OFF, 32'h5a);
    repeat (5) @(posedge MCLK);
    rdc("stopped count", timer8_pkg::COUNT_OFF, 32'h5a);
    wr(timer8_pkg::CTRL_B_OFF, 32'h1);
    wr(timer8_pkg::COUNT_OFF, 32'h40);
    rdc("write beats tick", timer8_pkg::COUNT_OFF, 32'h42);
    wr(timer8_pkg::CTRL_B_OFF, 32'h0);
  endtask

  task automatic t_wrap;
    wr(timer8_pkg::IRQ_EN_OFF, 32'h1);
    wr(timer8_pkg::COUNT_OFF, 32'hfd);
    wr(timer8_pkg::CTRL_B_OFF, 32'h1);
    wr(timer8_pkg::CTRL_B_OFF, 32'h0);
    rdc("wrapped count", timer8_pkg::COUNT_OFF, 32'h0);
    rdc("overflow set", timer8_pkg::FLAGS_OFF, 32'h1);
    @(negedge MCLK);
    chk("overflow irq", 32'h1, {31'h0, OVERFLOW_IRQ});
    wr(timer8_pkg::FLAGS_OFF, 32'h0);
    rdc("flag kept", timer8_pkg::FLAGS_OFF, 32'h1);
    wr(timer8_pkg::FLAGS_OFF, 32'h1);
    rdc("flag cleared", timer8_pkg::FLAGS_OFF, 32'h0);
    wr(timer8_pkg::IRQ_EN_OFF, 32'h0);
  endtask

  task automatic t_match;
    wr(timer8_pkg::IRQ_EN_OFF, 32'h6);
    wr(timer8_pkg::CMP_A_OFF, 32'h20);
    wr(timer8_pkg::CMP_B_OFF, 32'h22);
    wr(timer8_pkg::COUNT_OFF, 32'h20);
    wr(timer8_pkg::CTRL_B_OFF, 32'h1);
    wr(timer8_pkg::CTRL_B_OFF, 32'h0);
    rdc("match flags", timer8_pkg::FLAGS_OFF, 32'h4);
    @(negedge MCLK);
    chk("irq lines", 32'h2, {30'h0, COMPARE_B_IRQ, COMPARE_A_IRQ});
    @(posedge MCLK);
    COMPARE_B_ACK <= 1'b1;
    @(posedge MCLK);
    COMPARE_B_ACK <= 1'b0;
    rdc("acked flags", timer8_pkg::FLAGS_OFF, 32'h0);
    wr(timer8_pkg::IRQ_EN_OFF, 32'h0);
  endtask

  task automatic t_force;
    wr(timer8_pkg::PORT_OFF, 32'h3);
    wr(timer8_pkg::CTRL_A_OFF, 32'h70);
    @(negedge MCLK);
    chk("pins idle", 32'h0, pins());
    wr(timer8_pkg::CTRL_B_OFF, 32'hc0);
    wr(timer8_pkg::PORT_OFF, 32'hc);
    @(negedge MCLK);
    chk("pins forced", 32'hf, pins());
    rdc("no forced flag", timer8_pkg::FLAGS_OFF, 32'h0);
    wr(timer8_pkg::CTRL_A_OFF, 32'h30);
    @(negedge MCLK);
    chk("port data on pin", 32'he, pins());
    wr(timer8_pkg::CTRL_B_OFF, 32'h80);
    wr(timer8_pkg::CTRL_A_OFF, 32'h73);
    @(negedge MCLK);
    chk("state kept", 32'hf, pins());
    wr(timer8_pkg::CTRL_A_OFF, 32'h0);
    wr(timer8_pkg::PORT_OFF, 32'h0);
  endtask

  task automatic t_buffer;
    wr(timer8_pkg::CTRL_A_OFF, 32'h3);
    wr(timer8_pkg::CMP_B_OFF, 32'h3);
    wr(timer8_pkg::COUNT_OFF, 32'h2);
    wr(timer8_pkg::CTRL_B_OFF, 32'h1);
    wr(timer8_pkg::CTRL_B_OFF, 32'h0);
    rdc("buffered no match", timer8_pkg::FLAGS_OFF, 32'h0);
    rdc("buffer read", timer8_pkg::CMP_B_OFF, 32'h3);
    wr(timer8_pkg::CTRL_A_OFF, 32'h0);
  endtask

  task automatic t_async;
    wr(timer8_pkg::COUNT_OFF, 32'h0);
    wr(timer8_pkg::ASYNC_OFF, 32'h1);
    wr(timer8_pkg::CTRL_B_OFF, 32'h1);
    repeat (4) begin
      repeat (3) @(posedge MCLK);
      OSC_PIN_IN <= 1'b1;
      repeat (3) @(posedge MCLK);
      OSC_PIN_IN <= 1'b0;
    end
    repeat (4) @(posedge MCLK);
    wr(timer8_pkg::CTRL_B_OFF, 32'h0);
    wr(timer8_pkg::ASYNC_OFF, 32'h0);
    rdc("oscillator ticks", timer8_pkg::COUNT_OFF, 32'h4);
  endtask

  // clear on compare a: top comes from compare value a
  task automatic t_ctc;
    wr(timer8_pkg::CTRL_A_OFF, 32'h2);
    wr(timer8_pkg::CMP_A_OFF, 32'h5);
    wr(timer8_pkg::COUNT_OFF, 32'h4);
    wr(timer8_pkg::CTRL_B_OFF, 32'h1);
    wr(timer8_pkg::CTRL_B_OFF, 32'h0);
    rdc("top from compare a", timer8_pkg::COUNT_OFF, 32'h1);
    rdc("top match flag", timer8_pkg::FLAGS_OFF, 32'h2);
    @(posedge MCLK);
    COMPARE_A_ACK <= 1'b1;
    @(posedge MCLK);
    COMPARE_A_ACK <= 1'b0;
    rdc("serviced flag a", timer8_pkg::FLAGS_OFF, 32'h0);
    wr(timer8_pkg::CTRL_A_OFF, 32'h0);
  endtask

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog against a hung transfer
  initial begin
    repeat (5000) @(posedge MCLK);
    errors++;
    wrap_up();
  end

  // reset then the scenarios in turn
  initial begin
    repeat (12) @(posedge MCLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_count();
    t_wrap();
    t_match();
    t_force();
    t_buffer();
    t_async();
    t_ctc();
    wrap_up();
  end
endmodule

// checker on the top module ports
bind timer8_core timer8_checker u_chk (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .OSC_PIN_IN(OSC_PIN_IN), .OSC_PIN_OUT(OSC_PIN_OUT), .OVERFLOW_IRQ(OVERFLOW_IRQ),
  .COMPARE_A_IRQ(COMPARE_A_IRQ), .COMPARE_B_IRQ(COMPARE_B_IRQ), .COMPARE_B_ACK(COMPARE_B_ACK),
  .COMPARE_OUTPUT_A(COMPARE_OUTPUT_A), .COMPARE_OUTPUT_B_OE(COMPARE_OUTPUT_B_OE)
);
`default_nettype wire
